// *** hw/stb_consts.svh ***
`ifndef STB_CONSTS_SVH
`define STB_CONSTS_SVH

// register byte offsets, one aligned word each
`define STB_OFF_SERIAL_CONTROL_REGISTER 8'h00
`define STB_OFF_SERIAL_BUFFER 8'h04
`define STB_OFF_TIMER_MODE_CONTROL 8'h08
`define STB_OFF_TCTL 8'h0C
`define STB_OFF_T0LO 8'h10
`define STB_OFF_T0HI 8'h14
`define STB_OFF_T1LO 8'h18
`define STB_OFF_T1HI 8'h1C
`define STB_OFF_PWR 8'h20
`define STB_OFF_P2M 8'h24

// serial control field positions
`define STB_SC_RI 0
`define STB_SC_TI 1
`define STB_SC_RB8 2
`define STB_SC_TB8 3
`define STB_SC_REN 4
`define STB_SC_SM0 7

// timer control field positions
`define STB_TC_TF1 7
`define STB_TC_TR1 6
`define STB_TC_TF0 5
`define STB_TC_TR0 4

// timer mode control: nibble per timer
`define STB_TM_STRIDE 4
`define STB_TM_GATE 3
`define STB_TM_CT 2

// power control and port two mode positions
`define STB_PC_DOUBLE 7
`define STB_PC_FESEL 6
`define STB_P2_FIRST_TIMER_TOGGLE_ENABLE 0
`define STB_P2_SECOND_TIMER_TOGGLE_ENABLE 1

// reset values
`define STB_RST_BYTE 8'h00
`define STB_RST_LINE 1'b1

// timing counts
`define STB_CLK_MHZ 100
`define STB_MC_CLKS 6
`define STB_MC_LAST 3'h5
`define STB_SCLK_LOW_FIRST 3'h1
`define STB_SCLK_LOW_LAST 3'h3
`define STB_RX0_SAMPLE 3'h4
`define STB_DIV16_LAST 4'hF
`define STB_SAMPLE_POINT 4'h8
`define STB_BITS_M0 4'h8
`define STB_BITS_M1 4'hA
`define STB_BITS_M23 4'hB
`define STB_LAST_M1 4'h9
`define STB_LAST_M23 4'hA

`endif

// *** hw/stb_pkg.sv ***
package stb_pkg;

  typedef enum logic [1:0] {
    STB_TX_IDLE = 2'b00,
    STB_TX_SYNC = 2'b01,
    STB_TX_SEND = 2'b11
  } stb_tx_t;

  typedef enum logic [1:0] {
    STB_RX_IDLE = 2'b00,
    STB_RX_SHIFT = 2'b01,
    STB_RX_ASYNC = 2'b11
  } stb_rx_t;

  typedef enum logic [1:0] {
    STB_SM_SHIFT = 2'b00,
    STB_SM_UART8 = 2'b01,
    STB_SM_UART9F = 2'b10,
    STB_SM_UART9T = 2'b11
  } stb_smode_t;

  typedef struct packed {
    logic [7:0] timer_low_byte;
    logic [7:0] timer_high_byte;
    logic timer_run_bit;
    logic timer_overflow_flag;
    logic toggle_enable;
    logic toggle_out;
    logic pin_sample;
  } stb_tmr_t;

  typedef struct packed {
    logic [2:0] ph;
    stb_tmr_t [1:0] tmr;
    logic [7:0] timer_mode_control;
    logic [7:0] serial_control_register;
    logic framing_error_flag;
    logic baud_doubling_bit;
    logic framing_error_select;
    logic half;
    logic [3:0] div16;
    stb_tx_t tx_st;
    logic tx_step;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_line;
    stb_rx_t rx_st;
    logic rx_prev;
    logic rx_s;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] rx_buf;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic txd;
    logic rxd_o;
    logic rxd_oe;
  } stb_state_t;

endpackage

// *** hw/stb_serial_timer.sv ***
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "stb_consts.svh"
module stb_serial_timer
  import stb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  input wire logic first_timer_pin_in,
  output logic first_timer_pin_out,
  output logic first_timer_pin_oe,
  input wire logic second_timer_pin_in,
  output logic second_timer_pin_out,
  output logic second_timer_pin_oe,
  input wire logic external_interrupt_pin0,
  input wire logic external_interrupt_pin1
);

  stb_state_t st_reg;
  stb_state_t st_next;

  // returns {overflow, high, low} after one count
  function automatic logic [16:0] stb_step(input logic [1:0] m, input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    begin
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8 = {1'b0, lo} + 9'h001;
      case (m)
        2'h0: stb_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
        2'h1: stb_step = c16;
        2'h2: stb_step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
        default: stb_step = {c8[8], hi, c8[7:0]};
      endcase
    end
  endfunction

  always_comb begin
    stb_state_t n;
    logic mc, m3_0, tick16, roll, adv, rxb, ovfh, sclk_on;
    logic set_ti, set_ri, set_fe, set_rb8, rb8v, acc;
    logic [1:0] en, inc, ovf, pin_in, ext, tm;
    logic [16:0] s;
    logic [8:0] hc;
    logic [7:0] wd, rdv;
    logic [3:0] last;
    stb_smode_t sm;
    n = st_reg;
    mc = (st_reg.ph == `STB_MC_LAST);
    m3_0 = (st_reg.timer_mode_control[1:0] == 2'h3);
    sm = stb_smode_t'(st_reg.serial_control_register[7:6]);
    tick16 = 1'b0;
    roll = 1'b0;
    adv = 1'b0;
    rxb = rxd_in;
    ovfh = 1'b0;
    sclk_on = 1'b0;
    set_ti = 1'b0;
    set_ri = 1'b0;
    set_fe = 1'b0;
    set_rb8 = 1'b0;
    rb8v = 1'b0;
    en = 2'b00;
    inc = 2'b00;
    ovf = 2'b00;
    pin_in = {second_timer_pin_in, first_timer_pin_in};
    ext = {external_interrupt_pin1, external_interrupt_pin0};
    tm = 2'b00;
    s = 17'h00000;
    hc = 9'h000;
    wd = hwdata[7:0];
    rdv = `STB_RST_BYTE;
    last = (sm == STB_SM_UART8) ? `STB_LAST_M1 : `STB_LAST_M23;
    acc = hsel & htrans[1] & hready;

    // machine cycle divider: one pulse every six clocks
    n.ph = mc ? 3'h0 : st_reg.ph + 3'h1;

    // timers
    for (int i = 0; i < 2; i++) begin
      tm = st_reg.timer_mode_control[i*`STB_TM_STRIDE +: 2];
      en[i] = st_reg.tmr[i].timer_run_bit &
              (~st_reg.timer_mode_control[i*`STB_TM_STRIDE+`STB_TM_GATE] | ext[i]);
      // counter mode counts a high-then-low pair of machine-cycle samples
      inc[i] = st_reg.timer_mode_control[i*`STB_TM_STRIDE+`STB_TM_CT] ?
               (mc & st_reg.tmr[i].pin_sample & ~pin_in[i]) : mc;
      if (mc) begin
        n.tmr[i].pin_sample = pin_in[i];
      end
      if (i == 1) begin
        // with the first timer split, the second runs out of mode 3 whatever its run bit, still under its gate
        en[1] = (tm != 2'h3) & (m3_0 | st_reg.tmr[1].timer_run_bit) &
                (~st_reg.timer_mode_control[`STB_TM_STRIDE+`STB_TM_GATE] | ext[1]);
      end
      s = stb_step(tm, st_reg.tmr[i].timer_low_byte, st_reg.tmr[i].timer_high_byte);
      if (en[i] & inc[i]) begin
        n.tmr[i].timer_low_byte = s[7:0];
        n.tmr[i].timer_high_byte = s[15:8];
      end
      ovf[i] = en[i] & inc[i] & s[16];
      if (!st_reg.tmr[i].toggle_enable) begin
        n.tmr[i].toggle_out = 1'b1;
      end else if (ovf[i]) begin
        n.tmr[i].toggle_out = ~st_reg.tmr[i].toggle_out;
      end
    end
    // split mode: high byte counts machine cycles under the second run bit
    if (m3_0) begin
      hc = {1'b0, st_reg.tmr[0].timer_high_byte} + 9'h001;
      if (st_reg.tmr[1].timer_run_bit & mc) begin
        n.tmr[0].timer_high_byte = hc[7:0];
        ovfh = hc[8];
      end
    end

    // sixteen-times bit-rate tick
    if (sm == STB_SM_UART9F) begin
      n.half = st_reg.half ^ ~st_reg.baud_doubling_bit;
      tick16 = st_reg.baud_doubling_bit | st_reg.half;
    end else begin
      n.half = st_reg.half ^ ovf[1];
      tick16 = ovf[1] & (st_reg.baud_doubling_bit | st_reg.half);
    end
    roll = tick16 & (st_reg.div16 == `STB_DIV16_LAST);
    if (tick16) begin
      n.div16 = st_reg.div16 + 4'h1;
    end

    // transmitter: async bits change at the first machine cycle after a rollover
    adv = (sm == STB_SM_SHIFT) ? mc : (st_reg.tx_step & mc);
    n.tx_step = (st_reg.tx_step & ~adv) | roll;
    case (st_reg.tx_st)
      STB_TX_SYNC: begin
        if (adv) begin
          n.tx_st = STB_TX_SEND;
          n.tx_line = st_reg.tx_sh[0];
          n.tx_sh = {1'b1, st_reg.tx_sh[10:1]};
          n.tx_cnt = st_reg.tx_cnt - 4'h1;
        end
      end
      STB_TX_SEND: begin
        if (adv) begin
          if (st_reg.tx_cnt == 4'h0) begin
            n.tx_st = STB_TX_IDLE;
            n.tx_line = `STB_RST_LINE;
            set_ti = 1'b1;
          end else begin
            n.tx_line = st_reg.tx_sh[0];
            n.tx_sh = {1'b1, st_reg.tx_sh[10:1]};
            n.tx_cnt = st_reg.tx_cnt - 4'h1;
          end
        end
      end
      default: n.tx_st = STB_TX_IDLE;
    endcase

    // receiver: a detected start bit clears div16, which also paces the transmitter
    if (tick16) begin
      n.rx_prev = rxd_in;
    end
    case (st_reg.rx_st)
      STB_RX_IDLE: begin
        if (sm == STB_SM_SHIFT) begin
          if (st_reg.serial_control_register[`STB_SC_REN] & mc &
              ~st_reg.serial_control_register[`STB_SC_RI]) begin
            n.rx_st = STB_RX_SHIFT;
            n.rx_cnt = `STB_BITS_M0;
          end
        end else if (st_reg.serial_control_register[`STB_SC_REN] & tick16 &
                     st_reg.rx_prev & ~rxd_in) begin
          n.rx_st = STB_RX_ASYNC;
          n.rx_cnt = 4'h0;
          n.div16 = 4'h0;
        end
      end
      STB_RX_SHIFT: begin
        if (st_reg.ph == `STB_RX0_SAMPLE) begin
          n.rx_s = rxd_in;
        end
        if (mc) begin
          n.rx_sh[7:0] = {st_reg.rx_s, st_reg.rx_sh[7:1]};
          n.rx_cnt = st_reg.rx_cnt - 4'h1;
          if (st_reg.rx_cnt == 4'h1) begin
            n.rx_buf = n.rx_sh[7:0];
            set_ri = 1'b1;
            n.rx_st = STB_RX_IDLE;
          end
        end
      end
      STB_RX_ASYNC: begin
        if (tick16 & (st_reg.div16 == `STB_SAMPLE_POINT)) begin
          rxb = rxd_in;
          if (st_reg.rx_cnt == 4'h0 && rxb) begin
            n.rx_st = STB_RX_IDLE;
          end else begin
            if (st_reg.rx_cnt != 4'h0 && st_reg.rx_cnt <= `STB_LAST_M1) begin
              n.rx_sh[st_reg.rx_cnt - 4'h1] = rxb;
            end
            n.rx_cnt = st_reg.rx_cnt + 4'h1;
            if (st_reg.rx_cnt == last) begin
              // a byte still unread is simply replaced
              n.rx_buf = n.rx_sh[7:0];
              set_rb8 = 1'b1;
              rb8v = n.rx_sh[8];
              set_fe = ~rxb;
              set_ri = 1'b1;
              n.rx_st = STB_RX_IDLE;
            end
          end
        end
      end
      default: n.rx_st = STB_RX_IDLE;
    endcase

    // bus slave: writes take effect in the data phase, reads wait one cycle
    n.wr_pend = acc & hwrite;
    n.rd_pend = acc & ~hwrite;
    if (acc) begin
      n.addr = haddr[7:0];
    end
    n.hreadyout = ~(acc & ~hwrite);
    n.hresp = 1'b0;
    if (st_reg.addr == `STB_OFF_SERIAL_CONTROL_REGISTER) begin
      rdv = st_reg.serial_control_register;
      if (st_reg.framing_error_select) begin
        rdv[`STB_SC_SM0] = st_reg.framing_error_flag;
      end
    end else if (st_reg.addr == `STB_OFF_SERIAL_BUFFER) begin
      rdv = st_reg.rx_buf;
    end else if (st_reg.addr == `STB_OFF_TIMER_MODE_CONTROL) begin
      rdv = st_reg.timer_mode_control;
    end else if (st_reg.addr == `STB_OFF_TCTL) begin
      rdv = {st_reg.tmr[1].timer_overflow_flag, st_reg.tmr[1].timer_run_bit,
             st_reg.tmr[0].timer_overflow_flag, st_reg.tmr[0].timer_run_bit, 4'h0};
    end else if (st_reg.addr == `STB_OFF_T0LO) begin
      rdv = st_reg.tmr[0].timer_low_byte;
    end else if (st_reg.addr == `STB_OFF_T0HI) begin
      rdv = st_reg.tmr[0].timer_high_byte;
    end else if (st_reg.addr == `STB_OFF_T1LO) begin
      rdv = st_reg.tmr[1].timer_low_byte;
    end else if (st_reg.addr == `STB_OFF_T1HI) begin
      rdv = st_reg.tmr[1].timer_high_byte;
    end else if (st_reg.addr == `STB_OFF_PWR) begin
      rdv = {st_reg.baud_doubling_bit, st_reg.framing_error_select, 6'h00};
    end else if (st_reg.addr == `STB_OFF_P2M) begin
      rdv = {6'h00, st_reg.tmr[1].toggle_enable, st_reg.tmr[0].toggle_enable};
    end
    if (st_reg.rd_pend) begin
      n.hrdata = {24'h000000, rdv};
    end

    // software writes override counting; hardware flag sets are applied last
    if (st_reg.wr_pend) begin
      if (st_reg.addr == `STB_OFF_SERIAL_CONTROL_REGISTER) begin
        n.serial_control_register[6:0] = wd[6:0];
        if (st_reg.framing_error_select) begin
          n.framing_error_flag = wd[`STB_SC_SM0];
        end else begin
          n.serial_control_register[`STB_SC_SM0] = wd[`STB_SC_SM0];
        end
      end else if (st_reg.addr == `STB_OFF_SERIAL_BUFFER) begin
        // a new write restarts any frame in flight
        n.tx_st = STB_TX_SYNC;
        n.tx_step = 1'b0;
        if (sm == STB_SM_SHIFT) begin
          n.tx_sh = {3'b111, wd};
          n.tx_cnt = `STB_BITS_M0;
        end else if (sm == STB_SM_UART8) begin
          n.tx_sh = {2'b11, wd, 1'b0};
          n.tx_cnt = `STB_BITS_M1;
        end else begin
          n.tx_sh = {1'b1, st_reg.serial_control_register[`STB_SC_TB8], wd, 1'b0};
          n.tx_cnt = `STB_BITS_M23;
        end
      end else if (st_reg.addr == `STB_OFF_TIMER_MODE_CONTROL) begin
        n.timer_mode_control = wd;
      end else if (st_reg.addr == `STB_OFF_TCTL) begin
        n.tmr[1].timer_overflow_flag = wd[`STB_TC_TF1];
        n.tmr[1].timer_run_bit = wd[`STB_TC_TR1];
        n.tmr[0].timer_overflow_flag = wd[`STB_TC_TF0];
        n.tmr[0].timer_run_bit = wd[`STB_TC_TR0];
      end else if (st_reg.addr == `STB_OFF_T0LO) begin
        n.tmr[0].timer_low_byte = wd;
      end else if (st_reg.addr == `STB_OFF_T0HI) begin
        n.tmr[0].timer_high_byte = wd;
      end else if (st_reg.addr == `STB_OFF_T1LO) begin
        n.tmr[1].timer_low_byte = wd;
      end else if (st_reg.addr == `STB_OFF_T1HI) begin
        n.tmr[1].timer_high_byte = wd;
      end else if (st_reg.addr == `STB_OFF_PWR) begin
        n.baud_doubling_bit = wd[`STB_PC_DOUBLE];
        n.framing_error_select = wd[`STB_PC_FESEL];
      end else if (st_reg.addr == `STB_OFF_P2M) begin
        n.tmr[0].toggle_enable = wd[`STB_P2_FIRST_TIMER_TOGGLE_ENABLE];
        n.tmr[1].toggle_enable = wd[`STB_P2_SECOND_TIMER_TOGGLE_ENABLE];
      end
    end
    if (ovf[0]) begin
      n.tmr[0].timer_overflow_flag = 1'b1;
    end
    if (m3_0 ? ovfh : ovf[1]) begin
      n.tmr[1].timer_overflow_flag = 1'b1;
    end
    if (set_ti) begin
      n.serial_control_register[`STB_SC_TI] = 1'b1;
    end
    if (set_ri) begin
      n.serial_control_register[`STB_SC_RI] = 1'b1;
    end
    if (set_rb8) begin
      n.serial_control_register[`STB_SC_RB8] = rb8v;
    end
    if (set_fe) begin
      n.framing_error_flag = 1'b1;
    end

    // pins: mode 0 moves data on the receive pin and clocks on the transmit pin
    sclk_on = (n.tx_st == STB_TX_SEND) | (n.rx_st == STB_RX_SHIFT);
    if (sm == STB_SM_SHIFT) begin
      n.txd = ~(sclk_on & (n.ph >= `STB_SCLK_LOW_FIRST) &
                (n.ph <= `STB_SCLK_LOW_LAST));
      n.rxd_oe = (n.tx_st == STB_TX_SEND);
    end else begin
      n.txd = n.tx_line;
      n.rxd_oe = 1'b0;
    end
    n.rxd_o = n.tx_line;
    st_next = n;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.tmr[0].toggle_out <= 1'b1;
      st_reg.tmr[1].toggle_out <= 1'b1;
      st_reg.tx_line <= `STB_RST_LINE;
      st_reg.rx_prev <= `STB_RST_LINE;
      st_reg.txd <= `STB_RST_LINE;
      st_reg.hreadyout <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.hrdata;
  assign hreadyout = st_reg.hreadyout;
  assign hresp = st_reg.hresp;
  assign rxd_out = st_reg.rxd_o;
  assign rxd_oe = st_reg.rxd_oe;
  assign txd_out = st_reg.txd;
  assign first_timer_pin_out = st_reg.tmr[0].toggle_out;
  assign first_timer_pin_oe = st_reg.tmr[0].toggle_enable;
  assign second_timer_pin_out = st_reg.tmr[1].toggle_out;
  assign second_timer_pin_oe = st_reg.tmr[1].toggle_enable;

endmodule // stb_serial_timer

// *** verification/stb_monitor.sv ***
`timescale 1ns/10ps
module stb_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out,
  input wire logic first_timer_pin_in,
  input wire logic first_timer_pin_out,
  input wire logic first_timer_pin_oe,
  input wire logic second_timer_pin_in,
  input wire logic second_timer_pin_out,
  input wire logic second_timer_pin_oe,
  input wire logic external_interrupt_pin0,
  input wire logic external_interrupt_pin1
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = hsel && htrans[1] && hready;
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_rdata_upper: assert property (hreadyout && !$past(hreadyout) |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_rdata_hold: assert property ((!$past(take, 2) || $past(hwrite, 2)) |-> $stable(hrdata))
    else $error("read data moved without a read");
  // reset is checked on its own, so the default disable is overridden here
  chk_reset_idle: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> txd_out && hreadyout && !rxd_oe && !first_timer_pin_oe)
    else $error("outputs not idle after reset");
  chk_toggle_start: assert property ($rose(first_timer_pin_oe) |-> first_timer_pin_out)
    else $error("toggle pin not high when enabled");
  chk_pin_idle: assert property (!second_timer_pin_oe && !$past(second_timer_pin_oe)
    |-> second_timer_pin_out)
    else $error("disabled toggle pin not high");
  chk_sclk_low: assert property (rxd_oe && $fell(txd_out) |-> !txd_out [*3] ##1 txd_out)
    else $error("shift clock low time wrong");
  chk_sclk_high: assert property (rxd_oe && $rose(txd_out) |-> txd_out [*3])
    else $error("shift clock high time wrong");
  chk_sclk_data: assert property (rxd_oe && !txd_out && !$past(txd_out) |-> $stable(rxd_out))
    else $error("shift data moved while clock low");
endmodule // stb_monitor

// *** verification/stb_partner.sv ***
`timescale 1ns/10ps
module stb_partner (
  input wire logic clk,
  input wire logic txd,
  input wire logic dat0,
  output logic line
);
  // line rests at mark level like a pulled-up serial wire
  initial line = 1'b1;
  task automatic send(input logic [10:0] bits, input int n, input int cpb);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (cpb) @(posedge clk);
    end
    line <= 1'b1;
  endtask
  // samples mid-bit; unsampled top bits read as mark
  task automatic recv(input int n, input int cpb, output logic [10:0] bits);
    bits = 11'h7FF;
    @(negedge txd);
    repeat (cpb / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      if (i < n - 1) repeat (cpb) @(posedge clk);
    end
  endtask
  // mode 0 receive: next bit goes out as the shift clock falls
  task automatic shift_out(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      line <= b[i];
    end
    @(posedge txd);
    line <= 1'b1;
  endtask
  task automatic shift_in(output logic [7:0] b);
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      b[i] = dat0;
    end
  endtask
endmodule // stb_partner

// *** verification/stb_serial_timer_tb_top.sv ***
`timescale 1ns/10ps
`include "stb_consts.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module stb_serial_timer_tb_top;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, rxd_out, rxd_oe, txd_out, line;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, md;
  logic [2:0] hsize;
  logic t0_in, t0_out, t0_oe, t1_in, t1_out, t1_oe, int0, int1;
  logic [7:0] rv, sb;
  logic [10:0] fb;
  int mismatches, compares, cyc, cpb, n;
  wire rxd_in = rxd_oe ? rxd_out : line;
  stb_serial_timer dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .first_timer_pin_in(t0_in),
    .first_timer_pin_out(t0_out), .first_timer_pin_oe(t0_oe), .second_timer_pin_in(t1_in),
    .second_timer_pin_out(t1_out), .second_timer_pin_oe(t1_oe),
    .external_interrupt_pin0(int0), .external_interrupt_pin1(int1));
  stb_partner u_far (.clk(clk), .txd(txd_out), .dat0(rxd_out), .line(line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // whole run needs well under a fifth of this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata[7:0];
  endtask
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    t0_in = 1'b1;
    t1_in = 1'b1;
    int0 = 1'b1;
    int1 = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h00);
    `CHK("serial_control_register_rst", 8'h00, rv)
    xfer(1'b1, 8'h40, 8'h5A);
    xfer(1'b0, 8'h40, 8'h00);
    `CHK("unmapped", 8'h00, rv)
    // gated auto-reload: long reload period keeps the pin at one toggle
    xfer(1'b1, `STB_OFF_TIMER_MODE_CONTROL, 8'h0A);
    xfer(1'b1, `STB_OFF_T0HI, 8'h00);
    xfer(1'b1, `STB_OFF_T0LO, 8'hFE);
    xfer(1'b1, `STB_OFF_P2M, 8'h01);
    @(posedge clk);
    `CHK("pin_oe", 1'b1, t0_oe)
    `CHK("pin_first", 1'b1, t0_out)
    int0 <= 1'b0;
    xfer(1'b1, `STB_OFF_TCTL, 8'h10);
    repeat (30) @(posedge clk);
    xfer(1'b0, `STB_OFF_T0LO, 8'h00);
    `CHK("gated", 8'hFE, rv)
    int0 <= 1'b1;
    repeat (30) @(posedge clk);
    xfer(1'b0, `STB_OFF_TCTL, 8'h00);
    `CHK("tf0", 1'b1, rv[`STB_TC_TF0])
    `CHK("pin_toggled", 1'b0, t0_out)
    xfer(1'b0, `STB_OFF_T0LO, 8'h00);
    `CHK("reloaded", 4'h0, rv[7:4])
    xfer(1'b0, `STB_OFF_T0HI, 8'h00);
    `CHK("hi_kept", 8'h00, rv)
    // sixteen-bit mode: low byte wraps and carries into the high byte
    xfer(1'b1, `STB_OFF_TIMER_MODE_CONTROL, 8'h01);
    xfer(1'b1, `STB_OFF_T0HI, 8'h00);
    xfer(1'b1, `STB_OFF_T0LO, 8'hFF);
    repeat (30) @(posedge clk);
    xfer(1'b0, `STB_OFF_T0HI, 8'h00);
    `CHK("carry_high", 8'h01, rv)
    xfer(1'b0, `STB_OFF_T0LO, 8'h00);
    `CHK("low_wrapped", 4'h0, rv[7:4])
    // first run bit cleared before the low byte is zeroed, so it must hold
    xfer(1'b1, `STB_OFF_TIMER_MODE_CONTROL, 8'h33);
    xfer(1'b1, `STB_OFF_TCTL, 8'h40);
    xfer(1'b1, `STB_OFF_T0LO, 8'h00);
    xfer(1'b1, `STB_OFF_T0HI, 8'h00);
    xfer(1'b1, `STB_OFF_T1LO, 8'h00);
    repeat (60) @(posedge clk);
    xfer(1'b0, `STB_OFF_T0LO, 8'h00);
    `CHK("t0lo_idle", 8'h00, rv)
    xfer(1'b0, `STB_OFF_T0HI, 8'h00);
    `CHK("t0hi_runs", 1'b1, rv != 8'h00)
    xfer(1'b0, `STB_OFF_T1LO, 8'h00);
    `CHK("t1_stopped", 8'h00, rv)
    xfer(1'b1, `STB_OFF_PWR, 8'h80);
    xfer(1'b1, `STB_OFF_TIMER_MODE_CONTROL, 8'h23);
    xfer(1'b1, `STB_OFF_T1HI, 8'hFF);
    xfer(1'b1, `STB_OFF_T1LO, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      md = k == 0 ? 2'b10 : (k == 1 ? 2'b01 : 2'b11);
      cpb = md == 2'b10 ? 16 : 96;
      n = md == 2'b01 ? 10 : 11;
      xfer(1'b1, `STB_OFF_SERIAL_CONTROL_REGISTER, {md, 2'b01, md == 2'b11, 3'b000});
      fork
        u_far.recv(n, cpb, fb);
        u_far.send({1'b1, md == 2'b01, 8'h5A, 1'b0}, n, cpb);
        xfer(1'b1, `STB_OFF_SERIAL_BUFFER, 8'hA5);
      join
      `CHK("tx_frame", {1'b1, md != 2'b10, 8'hA5, 1'b0}, fb)
      repeat (cpb * 2) @(posedge clk);
      xfer(1'b0, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h00);
      `CHK("done_flags", 2'b11, rv[1:0])
      `CHK("rx_ninth", md == 2'b01, rv[`STB_SC_RB8])
      xfer(1'b0, `STB_OFF_SERIAL_BUFFER, 8'h00);
      `CHK("rx_byte", 8'h5A, rv)
    end
    xfer(1'b1, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h90);
    xfer(1'b1, `STB_OFF_PWR, 8'h40);
    xfer(1'b0, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h00);
    `CHK("fe_clear", 1'b0, rv[7])
    // undoubled mode 2 rate: 32 clocks per bit
    u_far.send({1'b0, 1'b0, 8'h11, 1'b0}, 11, 32);
    repeat (64) @(posedge clk);
    u_far.send({1'b1, 1'b0, 8'h22, 1'b0}, 11, 32);
    repeat (64) @(posedge clk);
    xfer(1'b0, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h00);
    `CHK("fe_sticky", 1'b1, rv[7])
    xfer(1'b0, `STB_OFF_SERIAL_BUFFER, 8'h00);
    `CHK("rx_overwrite", 8'h22, rv)
    xfer(1'b1, `STB_OFF_PWR, 8'h80);
    xfer(1'b0, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h00);
    `CHK("sm0_shown", 1'b1, rv[7])
    xfer(1'b1, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h00);
    fork
      u_far.shift_in(sb);
      xfer(1'b1, `STB_OFF_SERIAL_BUFFER, 8'h3C);
    join
    `CHK("shift_out", 8'h3C, sb)
    repeat (24) @(posedge clk);
    xfer(1'b0, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h00);
    `CHK("shift_done", 1'b1, rv[`STB_SC_TI])
    fork
      u_far.shift_out(8'hC3);
      xfer(1'b1, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h10);
    join
    repeat (12) @(posedge clk);
    xfer(1'b0, `STB_OFF_SERIAL_CONTROL_REGISTER, 8'h00);
    `CHK("shift_rx_done", 1'b1, rv[`STB_SC_RI])
    xfer(1'b0, `STB_OFF_SERIAL_BUFFER, 8'h00);
    `CHK("shift_in", 8'hC3, rv)
    stop_test();
  end
endmodule // stb_serial_timer_tb_top
bind stb_serial_timer stb_monitor u_mon (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
  .first_timer_pin_in(first_timer_pin_in), .first_timer_pin_out(first_timer_pin_out),
  .first_timer_pin_oe(first_timer_pin_oe), .second_timer_pin_in(second_timer_pin_in),
  .second_timer_pin_out(second_timer_pin_out), .second_timer_pin_oe(second_timer_pin_oe),
  .external_interrupt_pin0(external_interrupt_pin0),
  .external_interrupt_pin1(external_interrupt_pin1));
